// *** rtl/swd_pkg.sv ***
package swd_pkg;
    // ==================================================
    // Register indices (byte address is four times the index)
    localparam logic [7:0] SWD_IDX_RELOAD = 8'h86;
    localparam logic [7:0] SWD_IDX_INT_EN_ZERO = 8'ha8;
    localparam logic [7:0] SWD_IDX_INT_PRIO_ZERO = 8'ha9;
    localparam logic [7:0] SWD_IDX_INT_EN_ONE = 8'hb8;
    localparam logic [7:0] SWD_IDX_STAT = 8'hc0;
    localparam logic [7:0] SWD_IDX_MASK = 8'hc1;
    localparam logic [7:0] SWD_IDX_COUNT = 8'hc2;
    localparam int SWD_AW = 12;
    localparam int SWD_NSEL = 7;

    // ==================================================
    // Field positions
    localparam int SWD_GIE_BIT = 7;
    localparam int SWD_ARM_BIT = 6;
    localparam int SWD_START_BIT = 6;
    localparam int SWD_EXP_BIT = 6;
    localparam int SWD_PSEL_BIT = 7;
    localparam int SWD_NEV = 3;

    // ==================================================
    // Reset values and counts
    localparam logic [7:0] SWD_RST8 = 8'h00;
    localparam logic [15:0] SWD_RST16 = 16'h0000;
    localparam logic [15:0] SWD_TERMINAL = 16'h7cff;
    localparam logic [3:0] SWD_FLAG_CYCLES = 4'hc;
    localparam logic [3:0] SWD_DIV12_LAST = 4'hb;
    localparam logic [3:0] SWD_DIV16_LAST = 4'hf;
    localparam logic [8:0] SWD_GAP_SHORT = 9'h017;
    localparam logic [8:0] SWD_GAP_LONG = 9'h17f;

    // ==================================================
    // Types
    typedef enum logic [1:0] {
        SWD_IDLE = 2'b01,
        SWD_RUN = 2'b10
    } swd_state_e;

    typedef struct packed {
        logic arm_timeout;
        logic refresh;
        logic expiry;
    } swd_evt_s;
endpackage : swd_pkg

// *** rtl/swd_flag.sv ***
`timescale 1ns/1ps
module swd_flag
(
    // Clock and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic int_reset,
    // Control
    input wire logic set,
    input wire logic consume,
    // State
    output logic flag_r,
    output logic timeout_r
);
    import swd_pkg::*;

    logic [3:0] age_r;

    // ==================================================
    // Self-clearing flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_r <= 1'b0;
            age_r <= 4'h0;
            timeout_r <= 1'b0;
        end
        else if (int_reset)
        begin
            flag_r <= 1'b0;
            age_r <= 4'h0;
            timeout_r <= 1'b0;
        end
        else if (set)
        begin
            // A new set restarts the window and beats a consume
            flag_r <= 1'b1;
            age_r <= 4'h1;
            timeout_r <= 1'b0;
        end
        else if (flag_r && consume)
        begin
            flag_r <= 1'b0;
            age_r <= 4'h0;
            timeout_r <= 1'b0;
        end
        else if (flag_r && age_r == SWD_FLAG_CYCLES)
        begin
            flag_r <= 1'b0;
            age_r <= 4'h0;
            timeout_r <= 1'b1;
        end
        else
        begin
            age_r <= flag_r ? age_r + 4'h1 : 4'h0;
            timeout_r <= 1'b0;
        end
    end

    // ==================================================
    // Checks
    // Own count of cycles since the last set, so the checks do not lean on age_r
    logic [3:0] life_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            life_r <= 4'h0;
        else if (set)
            life_r <= 4'h1;
        else if (!flag_r)
            life_r <= 4'h0;
        else if (life_r != 4'hf)
            life_r <= life_r + 4'h1;
    end

    flag_life_a: assert property (@(posedge pclk) disable iff (!presetn)
        flag_r && life_r == SWD_FLAG_CYCLES && !set && !consume && !int_reset
        |=> !flag_r && timeout_r)
        else $error("flag did not clear twelve cycles after set");

    flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        flag_r && life_r < SWD_FLAG_CYCLES && !set && !consume && !int_reset |=> flag_r)
        else $error("flag cleared before twelve cycles");
endmodule : swd_flag

// *** rtl/swd_presc.sv ***
`timescale 1ns/1ps
module swd_presc
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic run,
    input wire logic sel16,
    // Count enable
    output logic tick_r
);
    import swd_pkg::*;

    logic div2_r;
    logic [3:0] div12_r;
    logic [3:0] div16_r;
    logic wrap12;

    assign wrap12 = div2_r && div12_r == SWD_DIV12_LAST;

    // ==================================================
    // Divide by 2, by 12, then optionally by 16
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div2_r <= 1'b0;
            div12_r <= 4'h0;
            div16_r <= 4'h0;
            tick_r <= 1'b0;
        end
        else if (!run)
        begin
            div2_r <= 1'b0;
            div12_r <= 4'h0;
            div16_r <= 4'h0;
            tick_r <= 1'b0;
        end
        else
        begin
            div2_r <= ~div2_r;
            if (div2_r)
                div12_r <= wrap12 ? 4'h0 : div12_r + 4'h1;
            if (wrap12)
                div16_r <= div16_r + 4'h1;
            tick_r <= wrap12 && (!sel16 || div16_r == SWD_DIV16_LAST);
        end
    end
endmodule : swd_presc

// *** rtl/swd_top.sv ***
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module swd_top
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Internal reset from the chip reset controller
    input wire logic int_reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [swd_pkg::SWD_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_r,
    output logic pready_r,
    output logic pslverr_r,
    // Watchdog results
    output logic reset_req_r,
    output logic irq_r
);
    import swd_pkg::*;

    swd_state_e state_r;
    swd_state_e state_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [7:0] reload_r;
    logic gie_r;
    logic exp_stat_r;
    swd_evt_s stat_r;
    swd_evt_s mask_r;
    swd_evt_s ev;
    logic [SWD_NSEL-1:0] wsel;
    logic [SWD_NSEL-1:0] rsel;
    logic wr_en;
    logic setup_rd;
    logic setup;
    logic [31:0] rd_nxt;
    logic running;
    logic tick;
    logic arm_flag;
    logic arm_timeout;
    logic start_flag;
    logic arm_set;
    logic start_set;
    logic do_refresh;
    logic expiry;

    // ==================================================
    // Address decode
    function automatic logic [SWD_NSEL-1:0] reg_sel(input logic [SWD_AW-1:0] a);
        logic [SWD_NSEL-1:0] s;
        s = '0;
        s[0] = a == {2'b00, SWD_IDX_RELOAD, 2'b00};
        s[1] = a == {2'b00, SWD_IDX_INT_EN_ZERO, 2'b00};
        s[2] = a == {2'b00, SWD_IDX_INT_PRIO_ZERO, 2'b00};
        s[3] = a == {2'b00, SWD_IDX_INT_EN_ONE, 2'b00};
        s[4] = a == {2'b00, SWD_IDX_STAT, 2'b00};
        s[5] = a == {2'b00, SWD_IDX_MASK, 2'b00};
        s[6] = a == {2'b00, SWD_IDX_COUNT, 2'b00};
        return s;
    endfunction : reg_sel

    assign setup = psel && !penable;
    assign setup_rd = setup && !pwrite;
    assign wr_en = psel && penable && pready_r && pwrite;
    assign rsel = reg_sel(paddr);
    assign wsel = wr_en ? rsel : '0;
    assign running = state_r == SWD_RUN;

    // ==================================================
    // APB handshake: no wait state; read data is captured into a flop at the end of the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            pready_r <= setup;
            pslverr_r <= setup && rsel == '0;
            if (setup_rd)
                prdata_r <= rd_nxt;
            else if (pready_r)
                prdata_r <= 32'h0000_0000;
        end
    end

    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        case (1'b1)
            rsel[0]: rd_nxt = {24'h000000, reload_r};
            rsel[1]: rd_nxt = {24'h000000, gie_r, arm_flag, 6'b000000};
            rsel[2]: rd_nxt = {24'h000000, 1'b0, exp_stat_r, 6'b000000};
            rsel[3]: rd_nxt = {24'h000000, 1'b0, start_flag, 6'b000000};
            rsel[4]: rd_nxt = {29'h00000000, stat_r};
            rsel[5]: rd_nxt = {29'h00000000, mask_r};
            rsel[6]: rd_nxt = {16'h0000, cnt_r};
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // ==================================================
    // Software controls
    assign arm_set = wsel[1] && pwdata[SWD_ARM_BIT];
    assign start_set = wsel[3] && pwdata[SWD_START_BIT];
    assign do_refresh = running && start_set && arm_flag;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reload_r <= SWD_RST8;
            gie_r <= 1'b0;
            mask_r <= '0;
        end
        else if (int_reset)
        begin
            reload_r <= SWD_RST8;
            gie_r <= 1'b0;
            mask_r <= '0;
        end
        else
        begin
            if (wsel[0])
                reload_r <= pwdata[7:0];
            if (wsel[1])
                gie_r <= pwdata[SWD_GIE_BIT];
            if (wsel[5])
                mask_r <= pwdata[SWD_NEV-1:0];
        end
    end

    swd_flag u_arm
    (
        .pclk(pclk),
        .presetn(presetn),
        .int_reset(int_reset),
        .set(arm_set),
        .consume(do_refresh),
        .flag_r(arm_flag),
        .timeout_r(arm_timeout)
    );

    swd_flag u_start
    (
        .pclk(pclk),
        .presetn(presetn),
        .int_reset(int_reset),
        .set(start_set),
        .consume(1'b0),
        .flag_r(start_flag),
        .timeout_r()
    );

    // ==================================================
    // Run state: nothing software writes leaves the run state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            SWD_IDLE: state_nxt = start_set ? SWD_RUN : SWD_IDLE;
            SWD_RUN: state_nxt = SWD_RUN;
            default: state_nxt = SWD_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_r <= SWD_IDLE;
        else if (int_reset)
            state_r <= SWD_IDLE;
        else
            state_r <= state_nxt;
    end

    // ==================================================
    // Counter
    swd_presc u_presc
    (
        .pclk(pclk),
        .presetn(presetn),
        .run(running && !int_reset),
        .sel16(reload_r[SWD_PSEL_BIT]),
        .tick_r(tick)
    );

    always_comb
    begin
        cnt_nxt = cnt_r;
        if (do_refresh)
            cnt_nxt = {1'b0, reload_r[6:0], 8'h00};
        else if (running && tick)
            cnt_nxt = cnt_r + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_r <= SWD_RST16;
        else if (int_reset)
            cnt_r <= SWD_RST16;
        else
            cnt_r <= cnt_nxt;
    end

    // ==================================================
    // Expiry, reset request and status
    // Expiry is a pure decode, so it follows the counter without delay
    assign expiry = running && cnt_r == SWD_TERMINAL;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reset_req_r <= 1'b0;
        else if (int_reset)
            reset_req_r <= 1'b0;
        else
            reset_req_r <= expiry;
    end

    // Power-on reset or a software write of zero clears it, int_reset does not, so a watchdog restart stays visible
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            exp_stat_r <= 1'b0;
        else if (expiry)
            exp_stat_r <= 1'b1;
        else if (wsel[2] && !pwdata[SWD_EXP_BIT])
            exp_stat_r <= 1'b0;
    end

    // ==================================================
    // Interrupt status, mask and output
    assign ev.expiry = expiry;
    assign ev.refresh = do_refresh;
    assign ev.arm_timeout = arm_timeout;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stat_r <= '0;
        else if (int_reset)
            stat_r <= '0;
        else if (wsel[4])
            stat_r <= (stat_r & ~swd_evt_s'(pwdata[SWD_NEV-1:0])) | ev;
        else
            stat_r <= stat_r | ev;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_r <= 1'b0;
        else
            irq_r <= gie_r && |(stat_r & mask_r);
    end

    // ==================================================
    // Checks
    logic [8:0] gap_r;
    logic gap_ok_r;

    // Cycles between count enables, valid only with a steady prescale choice
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gap_r <= 9'h000;
            gap_ok_r <= 1'b0;
        end
        else if (!running || int_reset || $changed(reload_r[SWD_PSEL_BIT]))
        begin
            gap_r <= 9'h000;
            gap_ok_r <= 1'b0;
        end
        else
        begin
            gap_r <= tick ? 9'h000 : gap_r + 9'h001;
            gap_ok_r <= gap_ok_r || tick;
        end
    end

    tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick && gap_ok_r && !int_reset && !$changed(reload_r[SWD_PSEL_BIT])
        |-> gap_r == (reload_r[SWD_PSEL_BIT] ? SWD_GAP_LONG : SWD_GAP_SHORT))
        else $error("count enable period wrong");

    cnt_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        running && tick && !do_refresh && !int_reset |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("counter did not advance by one");

    idle_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == SWD_IDLE |-> cnt_r == SWD_RST16 && !reset_req_r ##0 !expiry)
        else $error("idle watchdog not cleared");

    no_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        running && !int_reset |=> running)
        else $error("watchdog stopped without internal reset");

    start_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == SWD_IDLE && start_set && !int_reset |=> running ##1 running)
        else $error("start write did not start the watchdog");

    expiry_req_a: assert property (@(posedge pclk) disable iff (!presetn)
        expiry && !int_reset |=> reset_req_r && exp_stat_r)
        else $error("expiry did not request reset and set status");

    expiry_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        running && cnt_r == SWD_TERMINAL && tick && !do_refresh && !int_reset
        |=> !expiry ##1 !reset_req_r)
        else $error("expiry held after counter moved");

    reload_a: assert property (@(posedge pclk) disable iff (!presetn)
        do_refresh && !int_reset
        |=> cnt_r == {1'b0, $past(reload_r[6:0]), 8'h00} && !arm_flag)
        else $error("refresh reload wrong");

    no_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
        running && start_set && !arm_flag && !tick && !int_reset |=> $stable(cnt_r))
        else $error("reload without armed refresh");

    status_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        exp_stat_r && int_reset && !(wsel[2] && !pwdata[SWD_EXP_BIT]) |=> exp_stat_r)
        else $error("expiry status lost on internal reset");

    gie_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !gie_r |=> !irq_r)
        else $error("interrupt raised while globally disabled");

    refresh_c: cover property (@(posedge pclk) disable iff (!presetn)
        arm_set ##[1:12] do_refresh);
    timeout_c: cover property (@(posedge pclk) disable iff (!presetn)
        arm_timeout && running);
    expiry_c: cover property (@(posedge pclk) disable iff (!presetn)
        expiry ##1 reset_req_r);
    start_c: cover property (@(posedge pclk) disable iff (!presetn)
        state_r == SWD_IDLE && start_set);
endmodule : swd_top

// *** bench/swd_fw_model.sv ***
`timescale 1ns/1ps
// ==================================================
// Firmware model: APB master that issues register transfers
module swd_fw_model
(
    // Clock
    input wire logic pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [swd_pkg::SWD_AW-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata_r,
    input wire logic pready_r,
    input wire logic pslverr_r
);
    import swd_pkg::*;

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end

    // ==================================================
    // One transfer; the wait ends on pready_r, never on a fixed count
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait on a slave that never answers
        do
        begin
            @(posedge pclk);
        end
        while (pready_r !== 1'b1);
        q = prdata_r;
        e = pslverr_r;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released bus shows no stale value
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask : xfer

    // ==================================================
    // Refresh: arm, then start as the very next transfer
    task automatic refresh(input logic gie);
        logic [31:0] q;
        logic e;
        xfer(1'b1, SWD_IDX_INT_EN_ZERO, {24'h0, gie, 7'h40}, q, e);
        xfer(1'b1, SWD_IDX_INT_EN_ONE, 32'h40, q, e);
    endtask : refresh
endmodule : swd_fw_model

// *** bench/test_swd_top.sv ***
`timescale 1ns/1ps
module test_swd_top;
    import swd_pkg::*;
    logic pclk;
    logic presetn;
    logic int_reset;
    logic psel, penable, pwrite, pready_r, pslverr_r, reset_req_r, irq_r;
    logic [SWD_AW-1:0] paddr;
    logic [31:0] pwdata, prdata_r;
    int n_mismatch;
    int n_checks;
    int cyc;

    swd_top dut_u (.pclk(pclk), .presetn(presetn), .int_reset(int_reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
        .reset_req_r(reset_req_r), .irq_r(irq_r));

    swd_fw_model fw_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
        .pslverr_r(pslverr_r));

    // ==================================================
    // Clock and hang guard
    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ==================================================
    // Helpers
    task automatic end_of_test();
        if (n_mismatch == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic rd(input logic [7:0] idx, output logic [31:0] q);
        logic e;
        fw_u.xfer(1'b0, idx, 32'h0, q, e);
    endtask : rd

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        fw_u.xfer(1'b1, idx, d, q, e);
    endtask : wr

    task automatic chkrd(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        rd(idx, q);
        chk(nm, exp, q);
    endtask : chkrd

    // Cycles taken by k ticks, timed from a tick edge; poll grain is 3 cycles
    task automatic measure(input int k, output int n);
        logic [31:0] a, b;
        int t, i;
        rd(SWD_IDX_COUNT, a);
        b = a;
        for (i = 0; i < 2000 && b === a; i++) rd(SWD_IDX_COUNT, b);
        t = cyc;
        a = b;
        for (i = 0; i < 2000 && b !== a + k; i++) rd(SWD_IDX_COUNT, b);
        n = cyc - t;
    endtask : measure

    // ==================================================
    // Scenarios
    task automatic t_reset();
        logic [31:0] q;
        logic e;
        chkrd("reload", SWD_IDX_RELOAD, 32'h0);
        chkrd("int_enable_zero", SWD_IDX_INT_EN_ZERO, 32'h0);
        chkrd("int_priority_zero", SWD_IDX_INT_PRIO_ZERO, 32'h0);
        chkrd("int_enable_one", SWD_IDX_INT_EN_ONE, 32'h0);
        chkrd("count", SWD_IDX_COUNT, 32'h0);
        chkrd("status", SWD_IDX_STAT, 32'h0);
        chkrd("mask", SWD_IDX_MASK, 32'h0);
        fw_u.xfer(1'b1, 8'h10, 32'hff, q, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("reset_req idle", 32'h0, {31'h0, reset_req_r});
    endtask : t_reset

    task automatic t_run();
        int n;
        wr(SWD_IDX_INT_EN_ONE, 32'h40);
        chkrd("start flag", SWD_IDX_INT_EN_ONE, 32'h40);
        repeat (12) @(posedge pclk);
        chkrd("start flag cleared", SWD_IDX_INT_EN_ONE, 32'h0);
        // Zero writes must not stop a running watchdog
        wr(SWD_IDX_INT_EN_ONE, 32'h0);
        wr(SWD_IDX_INT_EN_ZERO, 32'h0);
        measure(10, n);
        chk("ten short ticks", 32'h1, {31'h0, n >= 237 && n <= 243});
        wr(SWD_IDX_RELOAD, 32'h80);
        measure(2, n);
        chk("two long ticks", 32'h1, {31'h0, n >= 765 && n <= 771});
    endtask : t_run

    task automatic t_refresh();
        logic [31:0] q, c;
        wr(SWD_IDX_RELOAD, 32'h45);
        fw_u.refresh(1'b0);
        rd(SWD_IDX_COUNT, q);
        chk("reloaded count", 32'h1, {31'h0, q === 32'h4500 || q === 32'h4501});
        chkrd("arm after refresh", SWD_IDX_INT_EN_ZERO, 32'h0);
        rd(SWD_IDX_STAT, q);
        chk("refresh event", 32'h2, q & 32'h2);
        wr(SWD_IDX_INT_EN_ZERO, 32'h40);
        chkrd("armed", SWD_IDX_INT_EN_ZERO, 32'h40);
        repeat (12) @(posedge pclk);
        chkrd("arm expired", SWD_IDX_INT_EN_ZERO, 32'h0);
        repeat (24) @(posedge pclk);
        rd(SWD_IDX_COUNT, c);
        wr(SWD_IDX_INT_EN_ONE, 32'h40);
        rd(SWD_IDX_COUNT, q);
        chk("late start no reload", 32'h1, {31'h0, q >= c && c > 32'h4500});
    endtask : t_refresh

    task automatic t_expiry();
        int i;
        wr(SWD_IDX_STAT, 32'h7);
        wr(SWD_IDX_MASK, 32'h1);
        wr(SWD_IDX_RELOAD, 32'h7c);
        fw_u.refresh(1'b1);
        for (i = 0; i < 7000 && reset_req_r !== 1'b1; i++) @(posedge pclk);
        chk("reset_req", 32'h1, {31'h0, reset_req_r});
        chkrd("count at expiry", SWD_IDX_COUNT, 32'h7cff);
        chkrd("expiry status", SWD_IDX_INT_PRIO_ZERO, 32'h40);
        chk("irq", 32'h1, {31'h0, irq_r});
        wr(SWD_IDX_INT_EN_ZERO, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq gated", 32'h0, {31'h0, irq_r});
        for (i = 0; i < 40 && reset_req_r !== 1'b0; i++) @(posedge pclk);
        chk("reset_req dropped", 32'h0, {31'h0, reset_req_r});
        chkrd("count moved on", SWD_IDX_COUNT, 32'h7d00);
        wr(SWD_IDX_INT_EN_ZERO, 32'h80);
        wr(SWD_IDX_STAT, 32'h1);
        repeat (3) @(posedge pclk);
        chk("irq after clear", 32'h0, {31'h0, irq_r});
        int_reset <= 1'b1;
        @(posedge pclk);
        int_reset <= 1'b0;
        chkrd("status survives", SWD_IDX_INT_PRIO_ZERO, 32'h40);
        chkrd("count halted", SWD_IDX_COUNT, 32'h0);
        repeat (60) @(posedge pclk);
        chkrd("count still halted", SWD_IDX_COUNT, 32'h0);
        wr(SWD_IDX_INT_PRIO_ZERO, 32'h0);
        chkrd("status cleared", SWD_IDX_INT_PRIO_ZERO, 32'h0);
    endtask : t_expiry

    // ==================================================
    // Main sequence
    initial
    begin
        presetn = 1'b0;
        int_reset = 1'b0;
        n_mismatch = 0;
        n_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_run();
        t_refresh();
        t_expiry();
        end_of_test();
    end
endmodule : test_swd_top
